// ===== verilog/cskd_pkg.sv
/*
 * Constants and types shared by the skip and operand decoder and its
 * machine-cycle divider.
 * Assumes one 100 MHz system clock and an instruction fetch stage that
 * classifies each instruction before handing it over.
 */
package cskd_pkg;

    // -------------------------------------------------------------
    // Instruction classes handed over by the fetch stage
    // -------------------------------------------------------------
    typedef enum logic [2:0] {
        CSKD_K_OTHER   = 3'h0,  // No skip, no carry, no bank effect
        CSKD_K_ADC_PTR = 3'h1,  // add_carry A through pointer_pair
        CSKD_K_SUB_PTR = 3'h2,  // sub_borrow A through pointer_pair
        CSKD_K_AIS     = 3'h3,  // add_skip A, immediate
        CSKD_K_SKIPCAP = 3'h4,  // Increment / decrement with skip
        CSKD_K_MBS     = 3'h5,  // mem_bank_select
        CSKD_K_RBS     = 3'h6,  // reg_bank_select
        CSKD_K_REF     = 3'h7   // lookup_exec
    } cskd_kind_e;

    // -------------------------------------------------------------
    // Register field decode
    // -------------------------------------------------------------
    typedef enum logic [2:0] {
        CSKD_R_SUM_NIB    = 3'h0,
        CSKD_R_SUM_HI_NIB = 3'h1,
        CSKD_R_PTR_BOTTOM = 3'h2,
        CSKD_R_PTR_TOP    = 3'h3,
        CSKD_R_PAIR1_LOW  = 3'h4,
        CSKD_R_PAIR1_UP   = 3'h5,
        CSKD_R_PAIR2_LOW  = 3'h6,
        CSKD_R_PAIR2_UP   = 3'h7
    } cskd_reg_e;

    typedef enum logic [1:0] {
        CSKD_P_SUM_PAIR     = 2'h0,
        CSKD_P_POINTER_PAIR = 2'h1,
        CSKD_P_PAIR1        = 2'h2,
        CSKD_P_PAIR2        = 2'h3
    } cskd_pair_e;

    // -------------------------------------------------------------
    // Sequencer states
    // -------------------------------------------------------------
    typedef enum logic [0:0] {
        CSKD_S_RUN     = 1'b0,
        CSKD_S_PENALTY = 1'b1
    } cskd_state_e;

    // -------------------------------------------------------------
    // Lengths, penalties, field positions
    // -------------------------------------------------------------
    localparam logic [1:0] CSKD_LEN_3BYTE   = 2'h3;
    localparam logic [1:0] CSKD_PEN_NONE    = 2'h0;
    localparam logic [1:0] CSKD_PEN_SHORT   = 2'h1;  // 1- or 2-byte skipped
    localparam logic [1:0] CSKD_PEN_LONG    = 2'h2;  // 3-byte skipped
    localparam logic [1:0] CSKD_PEN_REF     = 2'h1;  // lookup_exec skipped
    localparam int         CSKD_BANK_W      = 8;
    localparam int         CSKD_MBANK_LSB   = 4;     // Memory bank nibble
    localparam int         CSKD_RBANK_LSB   = 0;     // Register bank nibble
    localparam int         CSKD_IMM4_W      = 4;
    localparam int         CSKD_IMM8_W      = 8;
    localparam logic [7:0] CSKD_BANK_RST    = 8'h00;

    // -------------------------------------------------------------
    // CPU clock rate select and dividers
    // -------------------------------------------------------------
    localparam logic [1:0] CSKD_PCTL_SLOW   = 2'h0;
    localparam logic [1:0] CSKD_PCTL_MID    = 2'h1;
    localparam int         CSKD_DIV_SLOW    = 64;
    localparam int         CSKD_DIV_MID     = 8;
    localparam int         CSKD_DIV_FAST    = 4;

endpackage

// ===== verilog/cskd_mcyc_div.sv
/*
 * Machine-cycle enable divider: one-cycle pulse per selected CPU clock.
 * Assumes the rate select comes from logic on the same clock.
 */
`timescale 1ns/1ns
`default_nettype none

module cskd_mcyc_div
    import cskd_pkg::*;
#(
    parameter int DIV_SLOW = CSKD_DIV_SLOW,
    parameter int DIV_MID  = CSKD_DIV_MID,
    parameter int DIV_FAST = CSKD_DIV_FAST
) (
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       rstn_i,
    // Rate select and pulse
    input  wire logic [1:0] sel_i,
    output logic            en_o
);
    import cskd_pkg::*;

    typedef struct packed {
        logic [6:0] cnt;
        logic       en;
    } cskd_div_s;

    cskd_div_s  st_r;
    cskd_div_s  st_nxt;
    logic [6:0] last;

    // ---------------------------------------------------------
    // Terminal count follows the rate select at once
    // ---------------------------------------------------------
    always_comb begin
        case (sel_i)
            CSKD_PCTL_SLOW: last = 7'(DIV_SLOW - 1);
            CSKD_PCTL_MID:  last = 7'(DIV_MID - 1);
            default:        last = 7'(DIV_FAST - 1);
        endcase
        st_nxt = st_r;
        // Compare >= so a rate change mid-count never overruns
        if (st_r.cnt >= last) begin
            st_nxt.cnt = 7'h00;
            st_nxt.en  = 1'b1;
        end else begin
            st_nxt.cnt = st_r.cnt + 7'h01;
            st_nxt.en  = 1'b0;
        end
    end

    // State register
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign en_o = st_r.en;

endmodule

`default_nettype wire

// ===== verilog/cskd_top.sv
/*
 * Skip and operand decoder of a 4-bit CPU core: skip sequencing, the
 * carry/skip pairing, skip penalty cycles, register field and immediate
 * extraction, and the bank selection word.
 * Assumes a fetch stage that presents one classified instruction at a
 * time, holds it while BUSY_O is high, and an ALU that reports the
 * carry, overflow or borrow of the instruction it is executing.
 */
// What this block does
// - add_skip right after paired add_carry/sub_borrow never skips its follower.
// - add_carry overflow skips the add_skip; else all run in order.
// - sub_borrow without borrow skips the add_skip; with borrow all run.
// - Paired add_carry/sub_borrow raise skip signal and update carry flag.
// - Decode three-bit register field to nibble registers and eight-bit pairs.
// - Skip penalty: none, one cycle for 1/2-byte, two for 3-byte.
// - A skipped lookup_exec always costs exactly one machine cycle.
// - Bank select instructions are skippable; skipped ones keep banks unchanged.
// - One machine cycle per selected CPU clock, three rates by power_ctl.
// - Short immediates are 4-bit, long immediates 8-bit.
// - Eight-bit bank_select_word holds memory and register bank selections.
// - Increment, decrement, add_skip overflow skips next; carry flag unchanged.
`timescale 1ns/1ns
`default_nettype none

module cskd_top
    import cskd_pkg::*;
(
    // Clock and reset
    input  wire logic                   CLK_I,
    input  wire logic                   RSTN_I,
    // CPU clock rate from power_ctl
    input  wire logic [1:0]             PWR_SEL_I,
    // Instruction hand-over from fetch
    input  wire logic                   INSTR_VALID_I,
    input  wire cskd_pkg::cskd_kind_e   INSTR_KIND_I,
    input  wire logic [1:0]             INSTR_LEN_I,
    input  wire logic [7:0]             INSTR_B0_I,
    input  wire logic [7:0]             INSTR_B1_I,
    // ALU result flag of the executing instruction
    input  wire logic                   ALU_CARRY_I,
    // Sequencing
    output logic                        MCYC_EN_O,
    output logic                        BUSY_O,
    output logic                        TAKE_O,
    output logic                        SKIP_O,
    output logic                        SUPPRESS_O,
    output logic [1:0]                  PC_ADV_O,
    // Carry flag update
    output logic                        CARRY_WE_O,
    output logic                        CARRY_O,
    // Decoded operands
    output cskd_pkg::cskd_reg_e         REG_ID_O,
    output cskd_pkg::cskd_pair_e        PAIR_ID_O,
    output logic [CSKD_IMM4_W-1:0]      IMM4_O,
    output logic [CSKD_IMM8_W-1:0]      IMM8_O,
    // Bank selection word
    output logic [CSKD_BANK_W-1:0]      BANK_SEL_O
);
    import cskd_pkg::*;

    // ---------------------------------------------------------
    // State
    // ---------------------------------------------------------
    typedef struct packed {
        cskd_state_e            seq;
        logic [1:0]             pen;       // Penalty cycles left
        logic                   skip_pend; // Next instruction is skipped
        logic                   pair;      // Last take was executed paired arith
        logic                   skip;
        logic                   suppress;
        logic [1:0]             pc_adv;
        logic                   carry_we;
        logic                   carry;
        cskd_reg_e              reg_id;
        cskd_pair_e             pair_id;
        logic [CSKD_IMM4_W-1:0] imm4;
        logic [CSKD_IMM8_W-1:0] imm8;
        logic [CSKD_BANK_W-1:0] bank;
    } cskd_st_s;

    cskd_st_s st_r;
    cskd_st_s st_nxt;
    logic     mcyc_en;
    logic     take;

    // ---------------------------------------------------------
    // Decode functions
    // ---------------------------------------------------------
    // Nibble register from the r2..r0 field
    function automatic cskd_reg_e reg_decode(input logic [2:0] f);
        reg_decode = cskd_reg_e'(f);
    endfunction

    // Pair from the same field; r0 is ignored for pairs
    function automatic cskd_pair_e pair_decode(input logic [2:0] f);
        pair_decode = cskd_pair_e'(f[2:1]);
    endfunction

    // Penalty of skipping an instruction of the given kind and length
    function automatic logic [1:0] skip_penalty(input cskd_kind_e k,
                                                input logic [1:0] len);
        if (k == CSKD_K_REF) begin
            skip_penalty = CSKD_PEN_REF;
        end else if (len == CSKD_LEN_3BYTE) begin
            skip_penalty = CSKD_PEN_LONG;
        end else begin
            skip_penalty = CSKD_PEN_SHORT;
        end
    endfunction

    // ---------------------------------------------------------
    // Machine-cycle enable
    // ---------------------------------------------------------
    // One pulse per CPU clock; every sequencing step waits for it
    cskd_mcyc_div u_div (
        .clk_i  (CLK_I),
        .rstn_i (RSTN_I),
        .sel_i  (PWR_SEL_I),
        .en_o   (mcyc_en)
    );

    // An instruction is taken only in run state on a machine cycle
    assign take = mcyc_en && INSTR_VALID_I && (st_r.seq == CSKD_S_RUN);

    // ---------------------------------------------------------
    // Next state
    // ---------------------------------------------------------
    always_comb begin
        st_nxt          = st_r;
        st_nxt.skip     = 1'b0;
        st_nxt.suppress = 1'b0;
        st_nxt.pc_adv   = 2'h0;
        st_nxt.carry_we = 1'b0;

        case (st_r.seq)
            CSKD_S_RUN: begin
                if (take) begin
                    // Program counter always moves past the instruction
                    st_nxt.pc_adv = INSTR_LEN_I;
                    if (st_r.skip_pend) begin
                        // Discard: no carry, no bank, no new skip
                        st_nxt.suppress  = 1'b1;
                        st_nxt.skip_pend = 1'b0;
                        st_nxt.pair      = 1'b0;
                        st_nxt.pen       = skip_penalty(INSTR_KIND_I, INSTR_LEN_I);
                        st_nxt.seq       = CSKD_S_PENALTY;
                    end else begin
                        // Operands latched only for executed instructions
                        st_nxt.reg_id  = reg_decode(INSTR_B0_I[2:0]);
                        st_nxt.pair_id = pair_decode(INSTR_B0_I[2:0]);
                        st_nxt.imm4    = INSTR_B0_I[CSKD_IMM4_W-1:0];
                        st_nxt.imm8    = INSTR_B1_I;
                        st_nxt.pair    = 1'b0;
                        case (INSTR_KIND_I)
                            CSKD_K_ADC_PTR: begin
                                // Overflow skips a following add_skip
                                st_nxt.carry_we  = 1'b1;
                                st_nxt.carry     = ALU_CARRY_I;
                                st_nxt.skip_pend = ALU_CARRY_I;
                                st_nxt.skip      = ALU_CARRY_I;
                                st_nxt.pair      = 1'b1;
                            end
                            CSKD_K_SUB_PTR: begin
                                // No borrow is the skip condition here
                                st_nxt.carry_we  = 1'b1;
                                st_nxt.carry     = ALU_CARRY_I;
                                st_nxt.skip_pend = !ALU_CARRY_I;
                                st_nxt.skip      = !ALU_CARRY_I;
                                st_nxt.pair      = 1'b1;
                            end
                            CSKD_K_AIS: begin
                                // Muted right after paired arithmetic
                                st_nxt.skip_pend = ALU_CARRY_I && !st_r.pair;
                                st_nxt.skip      = ALU_CARRY_I && !st_r.pair;
                            end
                            CSKD_K_SKIPCAP: begin
                                // Carry flag deliberately left alone
                                st_nxt.skip_pend = ALU_CARRY_I;
                                st_nxt.skip      = ALU_CARRY_I;
                            end
                            CSKD_K_MBS: begin
                                st_nxt.bank[CSKD_MBANK_LSB +: CSKD_IMM4_W] =
                                    INSTR_B1_I[CSKD_IMM4_W-1:0];
                            end
                            CSKD_K_RBS: begin
                                st_nxt.bank[CSKD_RBANK_LSB +: CSKD_IMM4_W] =
                                    INSTR_B1_I[CSKD_IMM4_W-1:0];
                            end
                            default: begin
                            end
                        endcase
                    end
                end
            end
            CSKD_S_PENALTY: begin
                // Extra machine cycles after a discarded instruction
                if (mcyc_en) begin
                    if (st_r.pen <= CSKD_PEN_SHORT) begin
                        st_nxt.pen = CSKD_PEN_NONE;
                        st_nxt.seq = CSKD_S_RUN;
                    end else begin
                        st_nxt.pen = st_r.pen - 2'h1;
                    end
                end
            end
            default: begin
                st_nxt.seq = CSKD_S_RUN;
            end
        endcase
    end

    // ---------------------------------------------------------
    // State register
    // ---------------------------------------------------------
    // Bank word is part of the suppressed effects, hence by skip
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            st_r      <= '0;
            st_r.bank <= CSKD_BANK_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ---------------------------------------------------------
    // Outputs
    // ---------------------------------------------------------
    // Handshake terms combinational, data from the state register
    assign MCYC_EN_O  = mcyc_en;
    assign BUSY_O     = (st_r.seq == CSKD_S_PENALTY);
    assign TAKE_O     = take;
    assign SKIP_O     = st_r.skip;
    assign SUPPRESS_O = st_r.suppress;
    assign PC_ADV_O   = st_r.pc_adv;
    assign CARRY_WE_O = st_r.carry_we;
    assign CARRY_O    = st_r.carry;
    assign REG_ID_O   = st_r.reg_id;
    assign PAIR_ID_O  = st_r.pair_id;
    assign IMM4_O     = st_r.imm4;
    assign IMM8_O     = st_r.imm8;
    assign BANK_SEL_O = st_r.bank;

endmodule

`default_nettype wire

// ===== sim/cskd_top_chk.sv
/*
 * Concurrent checks on the ports of cskd_top: take strobe, machine-cycle
 * spacing, skip pairing, discard of skipped instructions, operand capture.
 * Assumes it is bound into cskd_top, one clock, active-low async reset.
 */
`timescale 1ns/1ns
`default_nettype none

module cskd_top_chk
    import cskd_pkg::*;
(
    // Clock and reset
    input wire logic                  CLK_I,
    input wire logic                  RSTN_I,
    // Inputs of the block
    input wire logic [1:0]            PWR_SEL_I,
    input wire logic                  INSTR_VALID_I,
    input wire cskd_pkg::cskd_kind_e  INSTR_KIND_I,
    input wire logic [1:0]            INSTR_LEN_I,
    input wire logic [7:0]            INSTR_B0_I,
    input wire logic [7:0]            INSTR_B1_I,
    input wire logic                  ALU_CARRY_I,
    // Outputs of the block
    input wire logic                  MCYC_EN_O,
    input wire logic                  BUSY_O,
    input wire logic                  TAKE_O,
    input wire logic                  SKIP_O,
    input wire logic                  SUPPRESS_O,
    input wire logic [1:0]            PC_ADV_O,
    input wire logic                  CARRY_WE_O,
    input wire logic                  CARRY_O,
    input wire cskd_pkg::cskd_reg_e   REG_ID_O,
    input wire cskd_pkg::cskd_pair_e  PAIR_ID_O,
    input wire logic [3:0]            IMM4_O,
    input wire logic [7:0]            IMM8_O,
    input wire logic [7:0]            BANK_SEL_O
);
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RSTN_I);

    // -------------------------------------------------------------
    // Helper state
    // -------------------------------------------------------------
    logic pend_r;  // Skip raised, next take must be discarded
    logic pair_r;  // Last take was executed and wrote the carry

    // Both clear on any take, since a skip or carry binds only the next one
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            pend_r <= 1'b0;
            pair_r <= 1'b0;
        end else if (TAKE_O) begin
            pend_r <= 1'b0;
            pair_r <= 1'b0;
        end else begin
            pend_r <= pend_r | SKIP_O;
            pair_r <= pair_r | CARRY_WE_O;
        end
    end

    // -------------------------------------------------------------
    // Assertions
    // -------------------------------------------------------------
    take_strobe_a: assert property (
        TAKE_O == (MCYC_EN_O && INSTR_VALID_I && !BUSY_O))
        else $error("take strobe does not follow its inputs");
    fast_rate_a: assert property (
        MCYC_EN_O && PWR_SEL_I == 2'h2 && $past(PWR_SEL_I, 4) == 2'h2 |->
        (##1 (!MCYC_EN_O) [*3] ##1 MCYC_EN_O) or (##[1:4] PWR_SEL_I != 2'h2))
        else $error("machine cycle spacing wrong at fastest rate");
    pc_advance_a: assert property (
        TAKE_O |=> PC_ADV_O == $past(INSTR_LEN_I))
        else $error("program counter advance differs from length");
    quiet_idle_a: assert property (
        !TAKE_O |=> PC_ADV_O == 2'h0 && !SKIP_O && !SUPPRESS_O && !CARRY_WE_O)
        else $error("result pulse without a take");
    skip_discard_a: assert property (
        TAKE_O |=> SUPPRESS_O == $past(pend_r))
        else $error("discard does not follow the pending skip");
    discard_clean_a: assert property (
        SUPPRESS_O |-> !SKIP_O && !CARRY_WE_O && $stable(BANK_SEL_O) && BUSY_O)
        else $error("discarded instruction left an effect");
    pair_noskip_a: assert property (
        TAKE_O && !pend_r && pair_r && INSTR_KIND_I == CSKD_K_AIS |=> !SKIP_O)
        else $error("paired immediate add raised a skip");
    add_carry_a: assert property (
        TAKE_O && !pend_r && INSTR_KIND_I == CSKD_K_ADC_PTR |=>
        SKIP_O == $past(ALU_CARRY_I) && CARRY_WE_O && CARRY_O == $past(ALU_CARRY_I))
        else $error("add with carry skip or carry wrong");
    sub_borrow_a: assert property (
        TAKE_O && !pend_r && INSTR_KIND_I == CSKD_K_SUB_PTR |=>
        SKIP_O == !$past(ALU_CARRY_I) && CARRY_WE_O && CARRY_O == $past(ALU_CARRY_I))
        else $error("subtract with borrow skip or carry wrong");
    count_skip_a: assert property (
        TAKE_O && !pend_r && INSTR_KIND_I == CSKD_K_SKIPCAP |=>
        SKIP_O == $past(ALU_CARRY_I) && !CARRY_WE_O)
        else $error("skip-capable instruction wrong");
    operand_take_a: assert property (
        TAKE_O && !pend_r |=> REG_ID_O == $past(INSTR_B0_I[2:0]) &&
        PAIR_ID_O == $past(INSTR_B0_I[2:1]) && IMM4_O == $past(INSTR_B0_I[3:0]) &&
        IMM8_O == $past(INSTR_B1_I))
        else $error("operand fields not captured");

    // Main scenarios reached
    cover property (SUPPRESS_O && PC_ADV_O == 2'h3);
    cover property (TAKE_O && pair_r && INSTR_KIND_I == CSKD_K_AIS);
    cover property (TAKE_O && pend_r && INSTR_KIND_I == CSKD_K_MBS);
endmodule

bind cskd_top cskd_top_chk u_chk (
    .CLK_I(CLK_I), .RSTN_I(RSTN_I), .PWR_SEL_I(PWR_SEL_I),
    .INSTR_VALID_I(INSTR_VALID_I), .INSTR_KIND_I(INSTR_KIND_I),
    .INSTR_LEN_I(INSTR_LEN_I), .INSTR_B0_I(INSTR_B0_I), .INSTR_B1_I(INSTR_B1_I),
    .ALU_CARRY_I(ALU_CARRY_I), .MCYC_EN_O(MCYC_EN_O), .BUSY_O(BUSY_O),
    .TAKE_O(TAKE_O), .SKIP_O(SKIP_O), .SUPPRESS_O(SUPPRESS_O), .PC_ADV_O(PC_ADV_O),
    .CARRY_WE_O(CARRY_WE_O), .CARRY_O(CARRY_O), .REG_ID_O(REG_ID_O),
    .PAIR_ID_O(PAIR_ID_O), .IMM4_O(IMM4_O), .IMM8_O(IMM8_O), .BANK_SEL_O(BANK_SEL_O));

`default_nettype wire

// ===== sim/test_cskd_top.sv
/*
 * Self-checking bench of cskd_top: rate dividers, skip pairing, penalties,
 * discard of skipped bank selects, operand capture, random instructions.
 * Assumes the hand-over timing of the block: result one cycle after take.
 */
`timescale 1ns/1ns
`default_nettype none

module test_cskd_top;
    import cskd_pkg::*;

    logic        CLK_I = 1'b0;
    logic        RSTN_I = 1'b0;
    logic [1:0]  PWR_SEL_I = 2'h2;
    logic        INSTR_VALID_I = 1'b0;
    cskd_kind_e  INSTR_KIND_I = CSKD_K_OTHER;
    logic [1:0]  INSTR_LEN_I = 2'h1;
    logic [7:0]  INSTR_B0_I = 8'h00;
    logic [7:0]  INSTR_B1_I = 8'h00;
    logic        ALU_CARRY_I = 1'b0;
    logic        MCYC_EN_O, BUSY_O, TAKE_O, SKIP_O, SUPPRESS_O, CARRY_WE_O, CARRY_O;
    logic [1:0]  PC_ADV_O;
    cskd_reg_e   REG_ID_O;
    cskd_pair_e  PAIR_ID_O;
    logic [3:0]  IMM4_O;
    logic [7:0]  IMM8_O, BANK_SEL_O;
    // Reference model of the block and result notes
    logic        pend = 1'b0, pair = 1'b0, cr = 1'b0, took_r = 1'b0;
    logic [2:0]  rg = 3'h0;
    logic [1:0]  pr = 2'h0, pen = 2'h0;
    logic [3:0]  i4 = 4'h0;
    logic [7:0]  i8 = 8'h00, bank = 8'h00;
    logic [31:0] seed = 32'h9993E3D2;
    logic [30:0] q[$];
    int          errors = 0, n_checks = 0, cyc = 0;

    cskd_top dut (.CLK_I(CLK_I), .RSTN_I(RSTN_I), .PWR_SEL_I(PWR_SEL_I),
        .INSTR_VALID_I(INSTR_VALID_I), .INSTR_KIND_I(INSTR_KIND_I),
        .INSTR_LEN_I(INSTR_LEN_I), .INSTR_B0_I(INSTR_B0_I), .INSTR_B1_I(INSTR_B1_I),
        .ALU_CARRY_I(ALU_CARRY_I), .MCYC_EN_O(MCYC_EN_O), .BUSY_O(BUSY_O),
        .TAKE_O(TAKE_O), .SKIP_O(SKIP_O), .SUPPRESS_O(SUPPRESS_O), .PC_ADV_O(PC_ADV_O),
        .CARRY_WE_O(CARRY_WE_O), .CARRY_O(CARRY_O), .REG_ID_O(REG_ID_O),
        .PAIR_ID_O(PAIR_ID_O), .IMM4_O(IMM4_O), .IMM8_O(IMM8_O), .BANK_SEL_O(BANK_SEL_O));

    // -------------------------------------------------------------
    // Clock, timeout, helpers
    // -------------------------------------------------------------
    always #5 CLK_I = ~CLK_I;

    // A hung handshake would stall the run, so the cycle count is capped
    always @(posedge CLK_I) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            end_sim();
        end
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction

    task automatic chk(input string nm, input logic [30:0] e, input logic [30:0] a);
        n_checks++;
        if (e !== a) begin
            errors++;
            $display("ERROR %s expected %h seen %h", nm, e, a);
        end
    endtask

    task automatic end_sim();
        if (errors == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Cycles between two machine-cycle pulses after the rate settles
    task automatic div_chk(input logic [1:0] sel, input int div);
        int n;
        PWR_SEL_I <= sel;
        for (int k = 0; k < 3; k++) begin
            n = 0;
            do begin
                @(posedge CLK_I);
                n++;
            end while (MCYC_EN_O !== 1'b1 && n < 200);
        end
        chk("machine cycle period", 31'(div), 31'(n));
    endtask

    // Presents one instruction, waits for its take, notes the result
    task automatic instr(input cskd_kind_e k, input logic [1:0] len,
                         input logic [7:0] b0, input logic [7:0] b1, input logic c);
        int  n;
        int  m;
        logic sk;
        INSTR_VALID_I <= 1'b1;
        INSTR_KIND_I <= k;
        INSTR_LEN_I <= len;
        INSTR_B0_I <= b0;
        INSTR_B1_I <= b1;
        ALU_CARRY_I <= c;
        n = 0;
        m = 0;
        do begin
            @(posedge CLK_I);
            n++;
            if (MCYC_EN_O === 1'b1 && TAKE_O !== 1'b1) m++;
        end while (TAKE_O !== 1'b1 && n < 400);
        chk("skip penalty", 31'(pen), 31'(m));
        if (pend) begin
            sk = 1'b0;
            pen = (k == CSKD_K_REF) ? CSKD_PEN_REF :
                  (len == CSKD_LEN_3BYTE) ? CSKD_PEN_LONG : CSKD_PEN_SHORT;
            pair = 1'b0;
            q.push_back({2'b01, len, 1'b0, cr, rg, pr, i4, i8, bank});
        end else begin
            pen = CSKD_PEN_NONE;
            sk = (k == CSKD_K_ADC_PTR && c) || (k == CSKD_K_SUB_PTR && !c) ||
                 (k == CSKD_K_AIS && c && !pair) || (k == CSKD_K_SKIPCAP && c);
            pair = (k == CSKD_K_ADC_PTR || k == CSKD_K_SUB_PTR);
            if (pair) cr = c;
            if (k == CSKD_K_MBS) bank[7:4] = b1[3:0];
            if (k == CSKD_K_RBS) bank[3:0] = b1[3:0];
            rg = b0[2:0];
            pr = b0[2:1];
            i4 = b0[3:0];
            i8 = b1;
            q.push_back({sk, 1'b0, len, pair, cr, rg, pr, i4, i8, bank});
        end
        pend = sk;
    endtask

    // Result check one cycle after each take, oldest note first
    always @(posedge CLK_I) begin
        if (took_r) begin
            chk("result", q.pop_front(), {SKIP_O, SUPPRESS_O, PC_ADV_O, CARRY_WE_O, CARRY_O,
                REG_ID_O, PAIR_ID_O, IMM4_O, IMM8_O, BANK_SEL_O});
        end
        took_r <= (TAKE_O === 1'b1);
    end

    // -------------------------------------------------------------
    // Main sequence
    // -------------------------------------------------------------
    initial begin
        repeat (6) @(posedge CLK_I);
        RSTN_I <= 1'b1;
        div_chk(2'h1, 8);
        div_chk(2'h0, 64);
        div_chk(2'h3, 4);
        div_chk(2'h2, 4);
        instr(CSKD_K_ADC_PTR, 2'h1, 8'h00, 8'h00, 1'b1);
        instr(CSKD_K_AIS,     2'h1, 8'h37, 8'h00, 1'b1);
        instr(CSKD_K_ADC_PTR, 2'h1, 8'h00, 8'h00, 1'b0);
        instr(CSKD_K_AIS,     2'h1, 8'h3F, 8'h00, 1'b1);
        instr(CSKD_K_SUB_PTR, 2'h1, 8'h00, 8'h00, 1'b0);
        instr(CSKD_K_AIS,     2'h1, 8'h31, 8'h00, 1'b0);
        instr(CSKD_K_SUB_PTR, 2'h1, 8'h00, 8'h00, 1'b1);
        instr(CSKD_K_AIS,     2'h1, 8'h32, 8'h00, 1'b1);
        instr(CSKD_K_SKIPCAP, 2'h1, 8'h05, 8'h00, 1'b1);
        instr(CSKD_K_OTHER,   2'h3, 8'h9C, 8'hA5, 1'b0);
        instr(CSKD_K_MBS,     2'h2, 8'h00, 8'h0A, 1'b0);
        instr(CSKD_K_RBS,     2'h2, 8'h00, 8'h03, 1'b0);
        instr(CSKD_K_AIS,     2'h1, 8'h34, 8'h00, 1'b1);
        instr(CSKD_K_MBS,     2'h2, 8'h00, 8'h06, 1'b0);
        instr(CSKD_K_SKIPCAP, 2'h1, 8'h06, 8'h00, 1'b1);
        instr(CSKD_K_REF,     2'h3, 8'h00, 8'h00, 1'b0);
        instr(CSKD_K_OTHER,   2'h2, 8'hE6, 8'h5B, 1'b0);
        // Random kinds, lengths and fields against the model
        for (int i = 0; i < 48; i++) begin
            seed = xs(seed);
            instr(cskd_kind_e'(seed[2:0]), 2'(seed[4:3] % 3 + 1),
                  seed[15:8], seed[23:16], seed[24]);
        end
        instr(CSKD_K_MBS, 2'h2, 8'h00, 8'h09, 1'b0);
        instr(CSKD_K_OTHER, 2'h1, 8'h00, 8'h00, 1'b0);
        INSTR_VALID_I <= 1'b0;
        repeat (20) @(posedge CLK_I);
        // Mid-run reset clears the bank word and the model
        RSTN_I <= 1'b0;
        @(posedge CLK_I);
        @(posedge CLK_I);
        chk("bank after reset", 31'(CSKD_BANK_RST), 31'(BANK_SEL_O));
        {pend, pair, cr, rg, pr, pen, i4, i8, bank} = '0;
        RSTN_I <= 1'b1;
        instr(CSKD_K_RBS, 2'h2, 8'h00, 8'h0C, 1'b0);
        instr(CSKD_K_OTHER, 2'h1, 8'h00, 8'h00, 1'b0);
        INSTR_VALID_I <= 1'b0;
        repeat (10) @(posedge CLK_I);
        end_sim();
    end
endmodule

`default_nettype wire
